// *** tt_map.svh ***
`ifndef TT_MAP_SVH
`define TT_MAP_SVH
// ==========================================================
// Register byte offsets
`define TT_OFS_CORE_CTRL 5'h00
`define TT_OFS_MAIN_TIMER 5'h04
`define TT_OFS_WD_CTRL 5'h08
`define TT_OFS_MASK_ONE 5'h0C
`define TT_OFS_MASK_TWO 5'h10
`define TT_OFS_FLAGS 5'h14
`define TT_OFS_CMD 5'h18
`define TT_OFS_CLK_SEL 5'h1C
// ==========================================================
// Field positions
`define TT_CC_GIE 6
`define TT_CC_TS 5
`define TT_CC_TE 4
`define TT_CC_MAIN_TIMER_PRESCALE_ENABLE 3
`define TT_WD_EN 7
`define TT_WD_WATCHDOG_PRESCALE_ENABLE 3
`define TT_CS_TCS 6
`define TT_CMD_WDC 0
`define TT_CMD_SLEEP 1
`define TT_CMD_GON 2
`define TT_CMD_GOFF 3
`define TT_FL_MAIN 0
// ==========================================================
// Implemented bits and reset values
`define TT_MASK_ONE_IMPL 8'h47
`define TT_MASK_TWO_IMPL 8'h28
`define TT_CORE_RST 8'h00
`define TT_WD_CTRL_RST 8'h00
`define TT_BYTE_RST 8'h00
`define TT_BYTE_ONES 8'hFF
`define TT_SEL_TOP 3'h7
// ==========================================================
// Timing
`define TT_WD_TIMEOUT_NS 16500000
`define TT_CLK_PERIOD_NS 10
`define TT_WD_STEPS 256
`define TT_SLOW_DIV 2
`endif

// *** tt_pkg.sv ***
package tt_pkg;
   // Avalon-MM request from the master
   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
   } tt_av_req_t;
   // Avalon-MM answer to the master
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } tt_av_rsp_t;
   // Interrupt flags raised elsewhere in the device
   typedef struct packed {
      logic convert_done_irq_flag;
      logic ext_pin_irq_flag;
      logic port_change_irq_flag;
      logic timer_three_irq_flag;
      logic timer_one_irq_flag;
   } tt_irq_src_t;
   // Power state of the core
   typedef enum logic [1:0] {
      TT_RUN = 2'b01,
      TT_SLEEP = 2'b10
   } tt_pwr_t;
endpackage : tt_pkg

// *** tt_timer_wdt.sv ***
`timescale 1ns/100ps
// How it works
// - two separate 8-bit prescalers, timer and watchdog
// - timer prescale ratio from core control field
// - watchdog ratio from watchdog control field
// - writing the timer clears its prescaler
// - watchdog clear or sleep clears watchdog, prescaler
// - 8-bit timer, internal or pin clock
// - internal, unscaled: one step per timer clock
// - pin source: one step per selected edge
// - timer halts while asleep
// - watchdog runs on its own tick, also asleep
// - enabled watchdog time-out resets the device
// - software may enable watchdog any time
// - unscaled watchdog times out near 16.5 ms
// - mask one bits 6,2,1,0 enable sources
// - unused mask bits always read zero
// - mask two bits 5,3 enable timers 3,1
// - global enable on/off instructions gate all
// - mask one reads back written bits 6,2,1,0 only
// - timer ratio 1:1, or 1:2 up to 1:256
// - watchdog ratio 1:1, or 1:2 up to 1:256
// - source bit 0 internal; edge bit 0 rising
// - watchdog control bit 7 enables watchdog
`include "tt_map.svh"

module tt_timer_wdt
   import tt_pkg::*;
#(
   parameter int WD_TIMEOUT_CYC =
      `TT_WD_TIMEOUT_NS / `TT_CLK_PERIOD_NS,
   parameter int SLOW_DIV = `TT_SLOW_DIV
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire tt_av_req_t av_req,
   output tt_av_rsp_t av_rsp,
   // Count pin and core events
   input wire logic count_pin,
   input wire logic wake,
   input wire tt_irq_src_t irq_src,
   // Results
   output logic irq,
   output logic wd_reset,
   output logic sleep
);

   // ==========================================================
   // Helpers

   // Prescaler hit: low sel+1 count bits all ones
   function automatic logic pre_hit(
      input logic [7:0] cnt,
      input logic [2:0] sel
   );
      logic [7:0] m;
      m = `TT_BYTE_ONES >> (`TT_SEL_TOP - sel);
      return (cnt & m) == m;
   endfunction : pre_hit

   // Watchdog base tick spacing, rounded down
   localparam int WD_TICK_CYC = WD_TIMEOUT_CYC / `TT_WD_STEPS;

   // ==========================================================
   // State

   // Bus answer held in a register
   tt_av_rsp_t rsp_q;
   // Core control without global enable bit
   logic [7:0] core_q;
   // Global interrupt enable
   logic gie_q;
   // Watchdog control
   logic [7:0] wdc_q;
   // Interrupt masks
   logic [7:0] mask1_q;
   logic [7:0] mask2_q;
   // Internal clock select
   logic tcs_q;
   // Main timer and its prescaler
   logic [7:0] main_timer_q;
   logic [7:0] mt_pre_q;
   // Main timer overflow flag
   logic mt_flag_q;
   // Watchdog counter and its prescaler
   logic [7:0] wd_cnt_q;
   logic [7:0] wd_pre_q;
   // Watchdog base tick divider
   logic [31:0] rc_cnt_q;
   // Slow internal clock divider
   logic [31:0] slow_cnt_q;
   // Pin synchroniser and settled level
   logic pin_s1_q;
   logic pin_s2_q;
   logic pin_s3_q;
   logic pin_lvl_q;
   // Power state
   tt_pwr_t pwr_q;
   // Registered outputs
   logic irq_q;
   logic wd_reset_q;

   // ==========================================================
   // Bus decode

   // Request seen while answer not yet given
   wire logic req = av_req.read | av_req.write;
   // Write takes effect at the edge master sees ack
   wire logic wr = av_req.write & ~rsp_q.waitrequest;
   wire logic [4:0] adr = av_req.address;
   wire logic [7:0] wdat = av_req.writedata[7:0];
   wire logic wr_core = wr && adr == `TT_OFS_CORE_CTRL;
   wire logic wr_mt = wr && adr == `TT_OFS_MAIN_TIMER;
   wire logic wr_wdc = wr && adr == `TT_OFS_WD_CTRL;
   wire logic wr_m1 = wr && adr == `TT_OFS_MASK_ONE;
   wire logic wr_m2 = wr && adr == `TT_OFS_MASK_TWO;
   wire logic wr_fl = wr && adr == `TT_OFS_FLAGS;
   wire logic wr_cmd = wr && adr == `TT_OFS_CMD;
   wire logic wr_cs = wr && adr == `TT_OFS_CLK_SEL;

   // Instruction strobes
   wire logic wdc_cmd = wr_cmd & wdat[`TT_CMD_WDC];
   wire logic slp_cmd = wr_cmd & wdat[`TT_CMD_SLEEP];
   wire logic gon_cmd = wr_cmd & wdat[`TT_CMD_GON];
   wire logic goff_cmd = wr_cmd & wdat[`TT_CMD_GOFF];

   // ==========================================================
   // Field views

   wire logic src_pin = core_q[`TT_CC_TS];
   wire logic edge_fall = core_q[`TT_CC_TE];
   wire logic main_timer_prescale_enable = core_q[`TT_CC_MAIN_TIMER_PRESCALE_ENABLE];
   wire logic [2:0] pst = core_q[2:0];
   wire logic wd_en = wdc_q[`TT_WD_EN];
   wire logic watchdog_prescale_enable = wdc_q[`TT_WD_WATCHDOG_PRESCALE_ENABLE];
   wire logic [2:0] psw = wdc_q[2:0];
   wire logic asleep = pwr_q == TT_SLEEP;

   // ==========================================================
   // Timer clock sources

   // Settled pin level change, counted once s2 and s3 agree
   wire logic pin_chg = (pin_s2_q == pin_s3_q) &&
      (pin_s3_q != pin_lvl_q);
   // Selected edge on the count pin
   wire logic pin_edge = pin_chg &&
      (pin_s3_q == ~edge_fall);
   // Slow internal rate pulse
   wire logic slow_en = slow_cnt_q == 32'(SLOW_DIV - 1);
   // Internal timer clock
   wire logic int_tick = tcs_q ? slow_en : 1'b1;
   // Chosen source tick
   wire logic src_tick = src_pin ? pin_edge : int_tick;
   // Timer prescaler output tick
   wire logic mt_pre_tick = src_tick &
      pre_hit(mt_pre_q, pst);
   // Timer step, halted in sleep
   wire logic mt_inc = ~asleep &
      (main_timer_prescale_enable ? mt_pre_tick : src_tick);
   // Timer wraps from all ones
   wire logic mt_wrap = mt_inc &&
      main_timer_q == `TT_BYTE_ONES;

   // ==========================================================
   // Watchdog sources

   // Free-running base tick, also in sleep
   wire logic rc_tick = rc_cnt_q == 32'(WD_TICK_CYC - 1);
   wire logic wd_pre_tick = rc_tick &
      pre_hit(wd_pre_q, psw);
   wire logic wd_inc = watchdog_prescale_enable ? wd_pre_tick : rc_tick;
   // Clear by instruction or entering sleep
   wire logic wd_clr = wdc_cmd | slp_cmd;
   // Time-out of an enabled watchdog
   wire logic wd_to = wd_en & wd_inc & ~wd_clr &&
      wd_cnt_q == `TT_BYTE_ONES;

   // ==========================================================
   // Interrupt gating

   wire logic [7:0] flags1 = {1'b0,
      irq_src.convert_done_irq_flag, 3'b000,
      irq_src.ext_pin_irq_flag,
      irq_src.port_change_irq_flag, mt_flag_q};
   wire logic [7:0] flags2 = {2'b00,
      irq_src.timer_three_irq_flag, 1'b0,
      irq_src.timer_one_irq_flag, 3'b000};
   wire logic any_irq = |(flags1 & mask1_q) |
      |(flags2 & mask2_q);

   // ==========================================================
   // Read data mux

   logic [7:0] rd_byte;

   // Select register by address
   always_comb begin
      case (adr)
         `TT_OFS_CORE_CTRL: rd_byte = {core_q[7], gie_q, core_q[5:0]};
         `TT_OFS_MAIN_TIMER: rd_byte = main_timer_q;
         `TT_OFS_WD_CTRL: rd_byte = wdc_q;
         `TT_OFS_MASK_ONE: rd_byte = mask1_q;
         `TT_OFS_MASK_TWO: rd_byte = mask2_q;
         `TT_OFS_FLAGS: rd_byte = flags1;
         `TT_OFS_CMD: rd_byte = {7'h00, asleep};
         `TT_OFS_CLK_SEL: rd_byte = {1'b0, tcs_q, 6'h00};
         default: rd_byte = `TT_BYTE_RST;
      endcase
   end

   // ==========================================================
   // Bus slave: one wait cycle, then ack

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rsp_q.waitrequest <= 1'b1;
         rsp_q.readdata <= 32'h0000_0000;
      end else if (req && rsp_q.waitrequest) begin
         // Answer on the next edge
         rsp_q.waitrequest <= 1'b0;
         rsp_q.readdata <= {24'h00_0000, rd_byte};
      end else begin
         // Ack lasts one cycle
         rsp_q.waitrequest <= 1'b1;
      end
   end

   // ==========================================================
   // Software registers

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         core_q <= `TT_CORE_RST;
         wdc_q <= `TT_WD_CTRL_RST;
         mask1_q <= `TT_BYTE_RST;
         mask2_q <= `TT_BYTE_RST;
         tcs_q <= 1'b0;
      end else begin
         // Time-out clears core control, keeps enable
         if (wd_to) begin
            core_q <= `TT_CORE_RST;
         end else if (wr_core) begin
            core_q <= wdat;
         end
         if (wr_wdc) begin
            wdc_q <= wdat;
         end
         if (wr_m1) begin
            mask1_q <= wdat & `TT_MASK_ONE_IMPL;
         end
         if (wr_m2) begin
            mask2_q <= wdat & `TT_MASK_TWO_IMPL;
         end
         if (wr_cs) begin
            tcs_q <= wdat[`TT_CS_TCS];
         end
      end
   end

   // Global enable: off wins when both arrive
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gie_q <= 1'b0;
      end else if (goff_cmd) begin
         gie_q <= 1'b0;
      end else if (gon_cmd) begin
         gie_q <= 1'b1;
      end
   end

   // ==========================================================
   // Pin synchroniser

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
         pin_lvl_q <= 1'b0;
      end else begin
         pin_s1_q <= count_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         // Track settled level
         if (pin_chg) begin
            pin_lvl_q <= pin_s3_q;
         end
      end
   end

   // Slow internal clock divider
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         slow_cnt_q <= 32'h0000_0000;
      end else if (slow_en) begin
         slow_cnt_q <= 32'h0000_0000;
      end else begin
         slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
      end
   end

   // ==========================================================
   // Main timer and prescaler

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mt_pre_q <= `TT_BYTE_RST;
      end else if (wr_mt) begin
         mt_pre_q <= `TT_BYTE_RST;
      end else if (main_timer_prescale_enable && src_tick && !asleep) begin
         mt_pre_q <= mt_pre_q + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         main_timer_q <= `TT_BYTE_RST;
      end else if (wr_mt) begin
         main_timer_q <= wdat;
      end else if (mt_inc) begin
         main_timer_q <= main_timer_q + 8'h01;
      end
   end

   // Overflow flag: wrap wins over software clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mt_flag_q <= 1'b0;
      end else if (mt_wrap) begin
         mt_flag_q <= 1'b1;
      end else if (wr_fl && wdat[`TT_FL_MAIN]) begin
         mt_flag_q <= 1'b0;
      end
   end

   // ==========================================================
   // Watchdog base tick divider

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rc_cnt_q <= 32'h0000_0000;
      end else if (rc_tick) begin
         rc_cnt_q <= 32'h0000_0000;
      end else begin
         rc_cnt_q <= rc_cnt_q + 32'h0000_0001;
      end
   end

   // Watchdog prescaler and counter
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wd_pre_q <= `TT_BYTE_RST;
         wd_cnt_q <= `TT_BYTE_RST;
      end else if (wd_clr || wd_to) begin
         wd_pre_q <= `TT_BYTE_RST;
         wd_cnt_q <= `TT_BYTE_RST;
      end else begin
         if (watchdog_prescale_enable && rc_tick) begin
            wd_pre_q <= wd_pre_q + 8'h01;
         end
         if (wd_en && wd_inc) begin
            wd_cnt_q <= wd_cnt_q + 8'h01;
         end
      end
   end

   // ==========================================================
   // Power state

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pwr_q <= TT_RUN;
      end else begin
         case (pwr_q)
            TT_RUN: begin
               if (slp_cmd) begin
                  pwr_q <= TT_SLEEP;
               end
            end
            TT_SLEEP: begin
               // Wake or time-out resumes running
               if (wake || wd_to) begin
                  pwr_q <= TT_RUN;
               end
            end
            default: pwr_q <= TT_RUN;
         endcase
      end
   end

   // ==========================================================
   // Outputs

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_q <= 1'b0;
         wd_reset_q <= 1'b0;
      end else begin
         irq_q <= gie_q & any_irq;
         wd_reset_q <= wd_to;
      end
   end

   assign av_rsp = rsp_q;
   assign irq = irq_q;
   assign wd_reset = wd_reset_q;
   assign sleep = asleep;

   // ==========================================================
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_mt_pre_clr: assert property (
      wr_mt |=> mt_pre_q == `TT_BYTE_RST)
      else $error("timer prescaler not cleared on write");

   chk_wd_clr: assert property (
      wd_clr |=> wd_cnt_q == `TT_BYTE_RST && wd_pre_q == `TT_BYTE_RST)
      else $error("watchdog not cleared");

   chk_sleep_hold: assert property (
      asleep && !wr_mt |=> main_timer_q == $past(main_timer_q))
      else $error("timer moved in sleep");

   chk_wd_timeout: assert property (
      wd_en && wd_inc && !wd_clr && wd_cnt_q == `TT_BYTE_ONES
      |=> wd_reset && wd_cnt_q == `TT_BYTE_RST)
      else $error("watchdog time-out missed");

   chk_wd_off: assert property (
      !wd_en |=> !wd_reset)
      else $error("disabled watchdog reset");

   chk_mask_zero: assert property (
      (mask1_q & ~`TT_MASK_ONE_IMPL) == `TT_BYTE_RST &&
      (mask2_q & ~`TT_MASK_TWO_IMPL) == `TT_BYTE_RST)
      else $error("unused mask bit set");

   chk_irq_gate: assert property (
      !gie_q |=> !irq)
      else $error("interrupt without global enable");

   chk_ovf_flag: assert property (
      mt_wrap && !wr_mt |=> main_timer_q == `TT_BYTE_RST ##0 mt_flag_q)
      else $error("overflow flag not set");

   chk_int_step: assert property (
      !src_pin && !tcs_q && !main_timer_prescale_enable && !asleep && !wr_mt
      |=> main_timer_q == $past(main_timer_q) + 8'h01)
      else $error("internal step wrong");

   chk_ext_step: assert property (
      src_pin && !main_timer_prescale_enable && !asleep && !wr_mt && pin_edge
      |=> main_timer_q == $past(main_timer_q) + 8'h01)
      else $error("pin edge not counted");

endmodule : tt_timer_wdt

// *** tt_pulse_src.sv ***
`timescale 1ns/100ps
// ==========================================================
// Count pin source model
module tt_pulse_src (
   // Clock
   input wire logic clk,
   // Pin
   output logic count_pin
);
   // Each level stands this many clocks beyond its launch edge
   localparam int HOLD = 4;
   // Pin rests low outside bursts
   initial count_pin = 1'b0;
   // Drive one level and hold it
   task automatic put(input logic v);
      @(posedge clk);
      count_pin <= v;
      repeat (HOLD) @(posedge clk);
   endtask : put
   // Whole pulses, rising edge then falling edge
   task automatic pulse(input int n);
      repeat (n) begin
         put(1'b1);
         put(1'b0);
      end
   endtask : pulse
endmodule : tt_pulse_src

// *** tt_timer_wdt_tb_top.sv ***
`timescale 1ns/100ps
`include "tt_map.svh"
// ==========================================================
// Bench for the timer, watchdog and mask block
module tt_timer_wdt_tb_top
   import tt_pkg::*;
;
   // Short watchdog: ten clocks per step
   localparam int WDC = 2560;
   // Short register offsets
   localparam logic [4:0] A_CC = `TT_OFS_CORE_CTRL;
   localparam logic [4:0] A_TM = `TT_OFS_MAIN_TIMER;
   localparam logic [4:0] A_WD = `TT_OFS_WD_CTRL;
   localparam logic [4:0] A_M1 = `TT_OFS_MASK_ONE;
   localparam logic [4:0] A_M2 = `TT_OFS_MASK_TWO;
   localparam logic [4:0] A_FL = `TT_OFS_FLAGS;
   localparam logic [4:0] A_CM = `TT_OFS_CMD;
   localparam logic [4:0] A_CS = `TT_OFS_CLK_SEL;
   // Mask place for each source flag, lowest flag first
   localparam logic [4:0] MA [5] = '{A_M2, A_M2, A_M1, A_M1, A_M1};
   localparam logic [7:0] MV [5] = '{8'h08, 8'h20, 8'h02, 8'h04, 8'h40};
   // Design signals
   logic clk, reset, count_pin, wake, irq, wd_reset, sleep;
   tt_av_req_t av_req;
   tt_av_rsp_t av_rsp;
   tt_irq_src_t irq_src;
   // Bookkeeping
   int fail_count = 0;
   int check_count = 0;
   logic [31:0] exp_q[$];
   string name_q[$];
   logic [31:0] rnd = 32'h909C;
   int n_sel;

   // ==========================================================
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================================
   // Design and pin source
   tt_timer_wdt #(.WD_TIMEOUT_CYC(WDC), .SLOW_DIV(2)) i_tt_timer_wdt (
      .clk(clk), .reset(reset), .av_req(av_req), .av_rsp(av_rsp),
      .count_pin(count_pin), .wake(wake), .irq_src(irq_src),
      .irq(irq), .wd_reset(wd_reset), .sleep(sleep));
   tt_pulse_src i_tt_pulse_src (.clk(clk), .count_pin(count_pin));

   // ==========================================================
   // Helpers
   // Random step
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Verdict and end of run
   task automatic wrap_up();
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   // Compare one value
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] e);
      check_count++;
      if (seen !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", s, e, seen);
      end
   endtask : check
   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic r, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      // Upper data bits carry noise that the block must ignore
      av_req <= '{read: r, write: !r, address: a, writedata: {rnd[31:8], d}};
      do begin
         @(posedge clk);
         n++;
      end while (av_rsp.waitrequest !== 1'b0 && n < 50);
      av_req <= '0;
      if (n >= 50) begin
         fail_count++;
         wrap_up();
      end
   endtask : bus
   // Write one register
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b0, a, d);
   endtask : wr
   // Read one register, noting what must come back
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string s);
      exp_q.push_back(e);
      name_q.push_back(s);
      bus(1'b1, a, 8'h00);
   endtask : rd
   // Wait for a watchdog pulse and check how long it took
   task automatic wait_wd(input int lo, input int hi);
      int n;
      n = 0;
      while (wd_reset !== 1'b1 && n < hi + 100) begin
         @(posedge clk);
         n++;
      end
      check("wd_time", 32'(n >= lo && n <= hi), 32'h1);
   endtask : wait_wd

   // ==========================================================
   // Read data watcher: oldest note against each answer
   always @(posedge clk) begin
      if (av_req.read === 1'b1 && av_rsp.waitrequest === 1'b0 && exp_q.size() > 0) begin
         check(name_q.pop_front(), av_rsp.readdata, exp_q.pop_front());
      end
   end

   // ==========================================================
   // Hang guard
   initial begin
      #1000000;
      fail_count++;
      wrap_up();
   end

   // ==========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      av_req = '0;
      wake = 1'b0;
      irq_src = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      // Reset values, one place off the word grid
      rd(A_M1, 32'h0, "mask_one");
      rd(A_M2, 32'h0, "mask_two");
      rd(A_WD, 32'h0, "wd_ctrl");
      rd(5'h03, 32'h0, "unmapped");
      // Implemented bits only
      wr(A_M1, 8'hFF);
      rd(A_M1, 32'h47, "mask_one");
      wr(A_M2, 8'hFF);
      rd(A_M2, 32'h28, "mask_two");
      wr(A_CC, 8'hFF);
      rd(A_CC, 32'hBF, "core");
      wr(A_WD, 8'hFF);
      wr(A_WD, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         wr(A_M1, rnd[7:0]);
         rd(A_M1, {24'h0, rnd[7:0] & 8'h47}, "mask_one");
      end
      wr(A_M1, 8'h00);
      wr(A_M2, 8'h00);
      // Internal source, 1:16, fast then slow clock
      for (int c = 0; c < 2; c++) begin
         n_sel = 16 << c;
         wr(A_CS, c ? 8'h40 : 8'h00);
         wr(A_CC, 8'h0B);
         wr(A_TM, 8'h00);
         repeat (n_sel * 5 + n_sel / 2) @(posedge clk);
         rd(A_TM, 32'h5, "timer");
      end
      wr(A_CS, 8'h00);
      // Internal source frozen while asleep
      wr(A_TM, 8'h00);
      wr(A_CM, 8'h02);
      repeat (200) @(posedge clk);
      check("sleep", 32'(sleep), 32'h1);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      rd(A_TM, 32'h0, "timer");
      check("sleep", 32'(sleep), 32'h0);
      // Pin source, no prescale, rising then falling edge
      wr(A_CC, 8'h20);
      wr(A_TM, 8'h00);
      i_tt_pulse_src.pulse(5);
      rd(A_TM, 32'h5, "timer");
      i_tt_pulse_src.put(1'b1);
      rd(A_TM, 32'h6, "timer");
      wr(A_CC, 8'h30);
      i_tt_pulse_src.put(1'b0);
      rd(A_TM, 32'h7, "timer");
      i_tt_pulse_src.put(1'b1);
      rd(A_TM, 32'h7, "timer");
      i_tt_pulse_src.put(1'b0);
      rd(A_TM, 32'h8, "timer");
      // Every prescale code, just short of the third step
      for (int s = 0; s < 8; s++) begin
         wr(A_CC, 8'h28 | 8'(s));
         wr(A_TM, 8'h00);
         i_tt_pulse_src.pulse(3 * (2 << s) - 1);
         rd(A_TM, 32'h2, "timer");
      end
      // Timer write drops a half-filled prescale count
      wr(A_CC, 8'h28);
      wr(A_TM, 8'h20);
      i_tt_pulse_src.pulse(1);
      wr(A_TM, 8'h20);
      i_tt_pulse_src.pulse(1);
      rd(A_TM, 32'h20, "timer");
      i_tt_pulse_src.pulse(1);
      rd(A_TM, 32'h21, "timer");
      // Pin pulses ignored while asleep
      wr(A_CC, 8'h20);
      wr(A_TM, 8'h10);
      wr(A_CM, 8'h02);
      i_tt_pulse_src.pulse(5);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      i_tt_pulse_src.pulse(3);
      rd(A_TM, 32'h13, "timer");
      // Wrap flag and global gate
      wr(A_M1, 8'h01);
      wr(A_CM, 8'h04);
      rd(A_CC, 32'h60, "core");
      wr(A_TM, 8'hFF);
      i_tt_pulse_src.pulse(1);
      check("irq", 32'(irq), 32'h1);
      rd(A_FL, 32'h1, "flags");
      rd(A_TM, 32'h0, "timer");
      wr(A_CM, 8'h0C);
      rd(A_CC, 32'h20, "core");
      check("irq", 32'(irq), 32'h0);
      wr(A_FL, 8'h01);
      wr(A_M1, 8'h00);
      wr(A_CM, 8'h04);
      // Each outside flag through its own mask bit
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         irq_src <= tt_irq_src_t'(5'h01 << i);
         wr(MA[i], MV[i]);
         repeat (3) @(posedge clk);
         check("irq", 32'(irq), 32'h1);
         wr(MA[i], 8'h00);
         // Random flags and wake level: all masks clear, so no interrupt
         rnd = xs(rnd);
         irq_src <= tt_irq_src_t'(rnd[4:0]);
         wake <= rnd[5];
         repeat (3) @(posedge clk);
         check("irq", 32'(irq), 32'h0);
      end
      wake <= 1'b0;
      wr(A_CM, 8'h08);
      // Watchdog restarted by clear or by sleep, then times out
      for (int k = 0; k < 2; k++) begin
         wr(A_CC, 8'h25);
         wr(A_WD, 8'h80);
         repeat (1500) @(posedge clk);
         wr(A_CM, k ? 8'h02 : 8'h01);
         // Let the power state settle before looking
         @(posedge clk);
         check("sleep", 32'(sleep), 32'(k));
         wait_wd(WDC - 40, WDC + 40);
         wr(A_WD, 8'h00);
         check("sleep", 32'(sleep), 32'h0);
         rd(A_CC, 32'h0, "core");
      end
      // Watchdog prescale 1:2
      wr(A_WD, 8'h88);
      wait_wd(2 * WDC - 60, 2 * WDC + 60);
      wr(A_WD, 8'h00);
      // Disabled part way: no time-out
      wr(A_WD, 8'h80);
      repeat (1000) @(posedge clk);
      wr(A_WD, 8'h00);
      // Count any reset pulse over a span past the would-be time-out
      n_sel = 0;
      repeat (3100) begin
         @(posedge clk);
         n_sel += 32'(wd_reset === 1'b1);
      end
      check("wd_off", 32'(n_sel), 32'h0);
      @(posedge clk);
      wrap_up();
   end
endmodule : tt_timer_wdt_tb_top
